// [design/chg_pkg.sv]
// constants and types shared by the charge controller files
package chg_pkg;
    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int ADC_W = 10;   // converter sample width
    localparam int DUTY_W = 16;  // pwm timer width
    localparam int ERR_W = 12;   // signed error width
    localparam int GAIN_W = 9;   // signed gain width

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;       // 250 MHz system clock
    localparam int TICK_MS = 5;             // duty reload period
    localparam int TICK_CYC = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TERM_S = 10;             // termination refresh period
    localparam int TERM_TICKS = TERM_S * 1000 / TICK_MS;

    // ----------------------------------------------------------------
    // control constants
    // ----------------------------------------------------------------
    localparam logic signed [GAIN_W-1:0] KP_GAIN = 9'h018;  // proportional_gain
    localparam logic signed [GAIN_W-1:0] KI_GAIN = 9'h1f4;  // integral_gain (negative, velocity form)
    localparam int GAIN_SHIFT = 6;          // fixed-point scale of the gains
    localparam int SAFE_SHIFT = 3;          // safety margin = set point / 8
    localparam int TERM_SHIFT = 3;          // termination current = 1C / 8
    localparam int ILIM_SHIFT = 2;          // current limit = 1C + 1C / 4
    localparam logic [DUTY_W-1:0] DUTY_RST = 16'h0000;
    localparam logic [DUTY_W-1:0] RELOAD_RST = 16'h0400;

    // ----------------------------------------------------------------
    // converter channels
    // ----------------------------------------------------------------
    localparam logic [1:0] CH_VOUT = 2'h0;
    localparam logic [1:0] CH_VBAT = 2'h1;
    localparam logic [1:0] CH_CUR = 2'h2;
    localparam logic [1:0] CH_TEMP = 2'h3;

    // main sequence states
    typedef enum logic [2:0] {
        ST_INIT = 3'b000,
        ST_SETPT = 3'b001,
        ST_CONV = 3'b010,
        ST_WAIT = 3'b011,
        ST_CHECK = 3'b100,
        ST_CTRL = 3'b101,
        ST_DONE = 3'b110,
        ST_FAULT = 3'b111
    } chg_state_t;
endpackage

// [design/chg_pwm_if.sv]
// link between the control sequencer and the pwm timer
interface chg_pwm_if;
    import chg_pkg::*;
    logic load;                  // one-cycle reload strobe
    logic [DUTY_W-1:0] duty;     // new pulse width
    logic [DUTY_W-1:0] reload;   // new period
    logic run;                   // high while the converter may switch
    modport ctl(output load, output duty, output reload, output run);
    modport tmr(input load, input duty, input reload, input run);
endinterface

// [design/chg_pwm_timer.sv]
// 16-bit pwm timer driving the converter switch
module chg_pwm_timer
    import chg_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    chg_pwm_if.tmr pif,
    output logic o_pwm
);
    import chg_pkg::*;

    logic [DUTY_W-1:0] cnt_r;     // period counter
    logic [DUTY_W-1:0] duty_r;    // active pulse width
    logic [DUTY_W-1:0] reload_r;  // active period
    logic wrap;                   // last count of the period

    assign wrap = (cnt_r >= reload_r - 16'h0001) || (reload_r == 16'h0000);

    // ----------------------------------------------------------------
    // period counter: a smaller reload gives a faster switch but fewer steps
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= 16'h0000;
        end else if (i_ce) begin
            if (wrap) begin
                cnt_r <= 16'h0000;  // [RL14] [RL15]
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    // shadow registers take the new values on the reload strobe
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            duty_r <= DUTY_RST;
            reload_r <= RELOAD_RST;
        end else if (i_ce && pif.load) begin
            duty_r <= pif.duty;      // [RL13]
            reload_r <= pif.reload;  // [RL14]
        end
    end

    // output from a flip-flop; dropping run kills the switch on the next enabled edge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pwm <= 1'b0;
        end else if (i_ce) begin
            o_pwm <= pif.run && (cnt_r < duty_r);  // [RL14]
        end
    end

    // high output implies the width it was compared against was nonzero;
    // the output lags the shadow register by one enabled edge
    AST_PWM_WIDTH: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL14]
        o_pwm |-> ($past(duty_r) != 16'h0000) || !$past(i_ce)) else $error("pwm high with zero duty");
endmodule

// [design/chg_ctrl.sv]
// closed-loop charge controller: sampling, safety, termination and pi duty
// Behaviour
// RL1: compute thresholds and set points once first
// RL2: loop runs until full charge or fault
// RL3: sample converter voltage, battery voltage, current
// RL4: sample temperature only with sensor fitted
// RL5: one current sample serves converter and battery
// RL6: analog feedback has ten-bit resolution
// RL7: safety crossing turns pwm off, faults
// RL8: full test only after all safety passes
// RL9: current below termination threshold ends charging; the code ends it only in cv mode
// RL10: otherwise compute new duty with pi
// RL11: duty change is kp*e plus ki*e_prev
// RL12: constant-voltage mode applies on/off current limit
// RL13: every 5 ms load latest duty
// RL14: 16-bit timer, reload sets period, duty width
// RL15: smaller reload, faster switching, fewer steps
// RL16: refresh termination tracking every 10 s
// RL17: start constant current, switch at threshold
// RL18: clamp duty between zero and reload
module chg_ctrl
    import chg_pkg::*;
#(
    parameter int P_TICK_CYC = chg_pkg::TICK_CYC  // cycles per 5 ms tick
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_has_temp_sensor,
    input wire logic [chg_pkg::ADC_W-1:0] i_volt_setpoint,
    input wire logic [chg_pkg::ADC_W-1:0] i_cur_setpoint,
    input wire logic [chg_pkg::ADC_W-1:0] i_temp_limit,
    input wire logic [chg_pkg::DUTY_W-1:0] i_reload,
    input wire logic i_adc_done,
    input wire logic [chg_pkg::ADC_W-1:0] i_adc_data,
    output logic o_adc_start,
    output logic [1:0] o_adc_chan,
    output logic o_pwm_output_pin,
    output logic o_charge_done,
    output logic o_safety_fault,
    output logic o_cv_mode
);
    import chg_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    chg_state_t state_r;                        // sequencer state
    logic [1:0] chan_r;                         // channel being converted
    logic [ADC_W-1:0] vout_r;                   // converter output voltage
    logic [ADC_W-1:0] battery_terminal_voltage_r;
    logic [ADC_W-1:0] charge_current_r;         // shared converter/battery current
    logic [ADC_W-1:0] temp_r;                   // battery temperature
    logic [ADC_W:0] vsafe_r;                    // voltage safety threshold
    logic [ADC_W-1:0] iterm_r;                  // termination current
    logic [ADC_W:0] ilim_r;                     // current limit in cv mode
    logic [ADC_W-1:0] vset_r;                   // voltage set point
    logic [ADC_W-1:0] iset_r;                   // 1C current set point
    logic signed [ERR_W-1:0] err_prev_r;        // error of the previous pass
    logic [DUTY_W-1:0] duty_r;                  // latest computed duty
    logic [DUTY_W-1:0] reload_r;                // reload latched with the duty
    logic [31:0] tick_cnt_r;                    // 5 ms divider
    logic tick;                                 // one-cycle 5 ms event
    logic [11:0] term_cnt_r;                    // 10 s count of ticks
    logic unsafe;                               // any safety crossing
    logic signed [ERR_W-1:0] err;               // present error
    logic signed [ERR_W+GAIN_W:0] delta;        // velocity-form increment
    logic [DUTY_W-1:0] duty_nxt;                // clamped new duty
    chg_pwm_if pif();                           // link to the timer

    // signed difference of two unsigned samples
    function automatic logic signed [ERR_W-1:0] diff(input logic [ADC_W:0] a, input logic [ADC_W:0] b);
        diff = $signed({1'b0, a}) - $signed({1'b0, b});
    endfunction

    // duty + increment held between zero and the reload value
    function automatic logic [DUTY_W-1:0] clamp(input logic [DUTY_W-1:0] d, input logic signed [ERR_W+GAIN_W:0] inc,
                                                 input logic [DUTY_W-1:0] top);
        logic signed [DUTY_W+ERR_W+GAIN_W:0] s;
        s = $signed({{(ERR_W+GAIN_W+1){1'b0}}, d}) + (ERR_W+GAIN_W+DUTY_W+1)'(inc);
        if (s < 0) begin
            clamp = 16'h0000;
        end else if (s > $signed({{(ERR_W+GAIN_W+1){1'b0}}, top})) begin
            clamp = top;
        end else begin
            clamp = s[DUTY_W-1:0];
        end
    endfunction

    // ----------------------------------------------------------------
    // combinational decision terms
    // ----------------------------------------------------------------
    assign unsafe = ({1'b0, vout_r} > vsafe_r) || ({1'b0, battery_terminal_voltage_r} > vsafe_r)
                    || (i_has_temp_sensor && (temp_r > i_temp_limit));  // [RL7]

    // cv tracks voltage unless the on/off limiter trips; cc tracks 1C
    always_comb begin
        if (!o_cv_mode) begin
            err = diff({1'b0, iset_r}, {1'b0, charge_current_r});  // [RL17]
        end else if ({1'b0, charge_current_r} > ilim_r) begin
            err = diff(ilim_r, {1'b0, charge_current_r});           // [RL12]
        end else begin
            err = diff({1'b0, vset_r}, {1'b0, vout_r});             // [RL10]
        end
        delta = (KP_GAIN * err + KI_GAIN * err_prev_r) >>> GAIN_SHIFT;  // [RL11]
    end

    // clamp against the period latched alongside, so a shrinking period
    // never leaves the duty above it
    assign duty_nxt = clamp(duty_r, delta, i_reload);  // [RL18]

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ST_INIT;
            chan_r <= CH_VOUT;
        end else if (i_ce) begin
            case (state_r)
                ST_INIT: state_r <= ST_SETPT;  // [RL1]
                ST_SETPT: state_r <= ST_CONV;
                ST_CONV: state_r <= ST_WAIT;
                ST_WAIT: begin
                    if (i_adc_done) begin
                        // the temperature conversion is skipped without a sensor
                        if (chan_r == CH_CUR && !i_has_temp_sensor) begin
                            chan_r <= CH_VOUT;  // [RL4]
                            state_r <= ST_CHECK;
                        end else if (chan_r == CH_TEMP) begin
                            chan_r <= CH_VOUT;
                            state_r <= ST_CHECK;
                        end else begin
                            chan_r <= chan_r + 2'h1;  // [RL3]
                            state_r <= ST_CONV;
                        end
                    end
                end
                ST_CHECK: begin
                    // safety first; the full test is reached only when safe
                    if (unsafe) begin
                        state_r <= ST_FAULT;  // [RL7] [RL8]
                    end else if (o_cv_mode && charge_current_r < iterm_r) begin
                        state_r <= ST_DONE;   // [RL9]
                    end else begin
                        state_r <= ST_CTRL;
                    end
                end
                ST_CTRL: state_r <= ST_CONV;  // [RL2]
                ST_DONE: state_r <= ST_DONE;  // terminal until reset [RL2]
                ST_FAULT: state_r <= ST_FAULT;
                default: state_r <= ST_FAULT;
            endcase
        end
    end

    // one-time thresholds and set points from the battery parameters
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vsafe_r <= 11'h000;
            iterm_r <= 10'h000;
            ilim_r <= 11'h000;
            vset_r <= 10'h000;
            iset_r <= 10'h000;
        end else if (i_ce && state_r == ST_INIT) begin
            vsafe_r <= {1'b0, i_volt_setpoint} + {4'h0, i_volt_setpoint[ADC_W-1:SAFE_SHIFT]};  // [RL1]
            iterm_r <= {3'h0, i_cur_setpoint[ADC_W-1:TERM_SHIFT]};
        end else if (i_ce && state_r == ST_SETPT) begin
            vset_r <= i_volt_setpoint;  // [RL1]
            iset_r <= i_cur_setpoint;
            ilim_r <= {1'b0, i_cur_setpoint} + {3'h0, i_cur_setpoint[ADC_W-1:ILIM_SHIFT]};
        end
    end

    // sample capture by channel
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            vout_r <= 10'h000;
            battery_terminal_voltage_r <= 10'h000;
            charge_current_r <= 10'h000;
            temp_r <= 10'h000;
        end else if (i_ce && state_r == ST_WAIT && i_adc_done) begin
            case (chan_r)
                CH_VOUT: vout_r <= i_adc_data;  // [RL6]
                CH_VBAT: battery_terminal_voltage_r <= i_adc_data;
                CH_CUR: charge_current_r <= i_adc_data;  // [RL5]
                CH_TEMP: temp_r <= i_adc_data;
                default: temp_r <= temp_r;
            endcase
        end
    end

    // gated by the enable so a frozen sequencer never holds a start high
    assign o_adc_start = (state_r == ST_CONV) && i_ce;
    assign o_adc_chan = chan_r;

    // pi update; duty and reload stay paired for the clamp
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            duty_r <= DUTY_RST;
            reload_r <= RELOAD_RST;
            err_prev_r <= 12'h000;
        end else if (i_ce && state_r == ST_CTRL) begin
            duty_r <= duty_nxt;  // [RL10] [RL18]
            err_prev_r <= err;   // [RL11]
            reload_r <= i_reload;
        end
    end

    // ----------------------------------------------------------------
    // 5 ms tick and 10 s termination refresh
    // ----------------------------------------------------------------
    assign tick = (tick_cnt_r == 32'(P_TICK_CYC - 1));

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_cnt_r <= 32'h0000_0000;
        end else if (i_ce) begin
            tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;  // [RL13]
        end
    end

    // cc to cv decision is re-taken only on the slow refresh, which keeps
    // noise on the battery sample from toggling the mode
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            term_cnt_r <= 12'h000;
            o_cv_mode <= 1'b0;
        end else if (i_ce && tick) begin
            if (term_cnt_r == 12'(TERM_TICKS - 1)) begin
                term_cnt_r <= 12'h000;  // [RL16]
                if (battery_terminal_voltage_r >= vset_r) begin
                    o_cv_mode <= 1'b1;  // [RL17]
                end
            end else begin
                term_cnt_r <= term_cnt_r + 12'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // timer link and status
    // ----------------------------------------------------------------
    assign pif.load = tick;        // [RL13]
    assign pif.duty = duty_r;
    assign pif.reload = reload_r;  // [RL15]
    assign pif.run = (state_r != ST_FAULT) && (state_r != ST_DONE);  // [RL7] [RL9]
    assign o_charge_done = (state_r == ST_DONE);
    assign o_safety_fault = (state_r == ST_FAULT);

    chg_pwm_timer u_pwm (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .pif(pif),
        .o_pwm(o_pwm_output_pin)
    );

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_INIT_ONCE: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL1]
        (state_r != ST_INIT) |=> (state_r != ST_INIT)) else $error("init re-entered");
    AST_DONE_HOLDS: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL2]
        o_charge_done |=> o_charge_done && !o_safety_fault) else $error("done left");
    AST_TEMP_SKIP: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL4]
        (o_adc_start && !i_has_temp_sensor) |-> (o_adc_chan != CH_TEMP)) else $error("temp sampled");
    AST_FAULT_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL7]
        (i_ce && state_r == ST_CHECK && unsafe) |=> o_safety_fault ##1 (!o_pwm_output_pin || !$past(i_ce)))
        else $error("pwm not off after fault");
    AST_SAFE_FIRST: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL8]
        (state_r == ST_DONE) |-> $past(!unsafe) || $past(state_r == ST_DONE)) else $error("done while unsafe");
    AST_FULL: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL9]
        (i_ce && state_r == ST_CHECK && !unsafe && o_cv_mode && charge_current_r < iterm_r) |=> o_charge_done)
        else $error("full charge missed");
    AST_TICK_LOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL13]
        (i_ce && tick_cnt_r == 32'(P_TICK_CYC - 2)) |=> pif.load ##1 (u_pwm.duty_r == $past(duty_r) || !$past(i_ce)))
        else $error("no duty load at tick");
    AST_CLAMP: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL18]
        (i_ce && state_r == ST_CTRL) |=> (duty_r <= reload_r)) else $error("duty above reload");
endmodule

// [verification/chg_adc_model.sv]
// behavioural model of the feedback amplifiers and sampling converter
module chg_adc_model
    import chg_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [1:0] i_chan,
    input wire logic [3:0] i_delay,
    input wire logic [chg_pkg::ADC_W-1:0] i_vout,
    input wire logic [chg_pkg::ADC_W-1:0] i_vbat,
    input wire logic [chg_pkg::ADC_W-1:0] i_cur,
    input wire logic [chg_pkg::ADC_W-1:0] i_temp,
    output logic o_done,
    output logic [chg_pkg::ADC_W-1:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    import chg_pkg::*;

    // ------------------------------------------------------------
    // conversion sequencing
    // ------------------------------------------------------------
    logic busy_r;        // a conversion is in flight
    logic [3:0] cnt_r;   // cycles left before the answer
    logic [1:0] chan_r;  // channel latched at start

    // answer after a programmable delay; data toggles while a conversion is
    // in flight so a stale result never passes for a fresh one; the answer
    // stands until the next start so a frozen controller still finds it
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_r <= 1'b0;
            cnt_r <= 4'h0;
            chan_r <= 2'h0;
            o_done <= 1'b0;
            o_data <= 10'h000;
        end else begin
            if (i_start) begin
                busy_r <= 1'b1;
                cnt_r <= i_delay;
                chan_r <= i_chan;
                o_done <= 1'b0;
                o_data <= ~o_data;
            end else if (busy_r && cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
                o_data <= ~o_data;
            end else if (busy_r) begin
                busy_r <= 1'b0;
                o_done <= 1'b1;
                // ten-bit results; one current value for both currents
                case (chan_r)
                    CH_VOUT: o_data <= i_vout;
                    CH_VBAT: o_data <= i_vbat;
                    CH_CUR: o_data <= i_cur;
                    default: o_data <= i_temp;
                endcase
            end
        end
    end
endmodule

// [verification/tb.sv]
// self-checking bench for the charge controller top
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import chg_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------
    localparam int TICK = 20;      // shortened tick keeps the 10 s refresh reachable
    localparam int RLD = 16;       // short period so the duty saturates fast
    localparam int LIMIT = 60000;  // run ceiling in cycles
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_ce = 1'b1;
    logic sensor = 1'b0;
    logic [ADC_W-1:0] vout = 10'h200;
    logic [ADC_W-1:0] vbat = 10'h1f0;
    logic [ADC_W-1:0] cur = 10'h000;
    logic [ADC_W-1:0] temp = 10'h000;
    logic [DUTY_W-1:0] reload = 16'h0010;
    logic [3:0] dly = 4'h2;        // converter answer delay
    logic adone, start, pwm, cdone, fault, cv;
    logic [1:0] chan;
    logic [ADC_W-1:0] adata;
    logic [1:0] chq[$];            // channels seen at each start
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;

    always #2 i_clk = ~i_clk;

    chg_ctrl #(.P_TICK_CYC(TICK)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
        .i_has_temp_sensor(sensor), .i_volt_setpoint(10'h200), .i_cur_setpoint(10'h200),
        .i_temp_limit(10'h100), .i_reload(reload), .i_adc_done(adone), .i_adc_data(adata),
        .o_adc_start(start), .o_adc_chan(chan), .o_pwm_output_pin(pwm), .o_charge_done(cdone),
        .o_safety_fault(fault), .o_cv_mode(cv));
    chg_adc_model i_adc (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(start), .i_chan(chan),
        .i_delay(dly), .i_vout(vout), .i_vbat(vbat), .i_cur(cur), .i_temp(temp),
        .o_done(adone), .o_data(adata));

    // record every conversion request; cut a hang short
    always @(posedge i_clk) begin
        cyc++;
        if (start === 1'b1) begin
            chq.push_back(chan);
        end
        if (cyc == LIMIT) begin
            err_total++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // count pwm high cycles over two periods
    task automatic count_hi(output int h);
        h = 0;
        repeat (2 * RLD) begin
            @(negedge i_clk);
            h += (pwm === 1'b1) ? 1 : 0;
        end
    endtask

    // reset with a fresh battery picture; outputs must be quiet in reset
    task automatic start_run(input logic s, input logic [9:0] vo, vb, cu, te);
        @(negedge i_clk);
        i_rst_n = 1'b0;
        sensor = s;
        vout = vo;
        vbat = vb;
        cur = cu;
        temp = te;
        cycles(3);
        chk({9'h000, start, chan, pwm, cdone, fault, cv}, 16'h0000);
        cycles(5);
        chq.delete();
        i_rst_n = 1'b1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic sc_startup();
        start_run(1'b0, 10'h200, 10'h1f0, 10'h000, 10'h000);
        cycles(1);
        chk({13'h0000, start, chan}, 16'h0000);
        cycles(1);
        chk({13'h0000, start, chan}, 16'h0004);
    endtask

    task automatic sc_order(input logic s, input logic [3:0] d);
        dly = d;
        start_run(s, 10'h200, 10'h1f0, 10'h000, 10'h000);
        cycles(160);
        chk(chq.size() >= 8, 1);
        for (int i = 0; i < 8 && i < chq.size(); i++) begin
            chk(chq[i], s ? i % 4 : i % 3);
        end
        dly = 4'h2;
    endtask

    // large errors drive the duty to both clamp ends
    task automatic sc_pwm();
        int h;
        int n;
        start_run(1'b0, 10'h200, 10'h1f0, 10'h000, 10'h000);
        cycles(10 * TICK);
        count_hi(h);
        chk(h, 2 * RLD);
        // a low enable freezes the sequencer and the switch output
        i_ce = 1'b0;
        n = chq.size();
        cycles(40);
        chk({chq.size() == n, pwm}, 16'h0003);
        i_ce = 1'b1;
        cur = 10'h3ff;
        cycles(10 * TICK);
        count_hi(h);
        chk(h, 0);
        chk({fault, cdone}, 0);
    endtask

    task automatic one_fault(input logic s, input logic [9:0] vo, vb, te, input logic exp);
        int h;
        int n;
        // start safe so the switch is running before the crossing
        start_run(s, 10'h200, 10'h1f0, 10'h000, 10'h000);
        cycles(60);
        vout = vo;
        vbat = vb;
        temp = te;
        cycles(100);
        chk(fault, exp);
        chk(cdone, 0);
        n = chq.size();
        count_hi(h);
        chk(h, exp ? 0 : 2 * RLD);
        if (exp) begin
            chk(chq.size(), n);
        end
    endtask

    // just above and at the margin, battery side, temperature with and without sensor
    task automatic sc_fault();
        one_fault(1'b0, 10'h241, 10'h1f0, 10'h000, 1'b1);
        one_fault(1'b0, 10'h240, 10'h1f0, 10'h000, 1'b0);
        one_fault(1'b0, 10'h200, 10'h241, 10'h000, 1'b1);
        one_fault(1'b1, 10'h200, 10'h1f0, 10'h101, 1'b1);
        one_fault(1'b0, 10'h200, 10'h1f0, 10'h3ff, 1'b0);
    endtask

    // voltage mode comes only with the refresh; then the current limiter
    // overrides the voltage loop, and low current ends charging
    task automatic sc_cv();
        int n;
        int h;
        start_run(1'b0, 10'h100, 10'h200, 10'h100, 10'h000);
        cycles(1995 * TICK);
        chk({cv, cdone}, 0);
        for (int i = 0; i < 20 * TICK && cv !== 1'b1; i++) begin
            cycles(1);
        end
        chk(cv, 1);
        cycles(3 * TICK);
        count_hi(h);
        chk(h, 2 * RLD);
        chk(cdone, 0);
        cur = 10'h3ff;
        cycles(4 * TICK);
        count_hi(h);
        chk(h, 0);
        cur = 10'h010;
        for (int i = 0; i < 20 * TICK && cdone !== 1'b1; i++) begin
            cycles(1);
        end
        chk({cv, cdone, fault}, 3'b110);
        n = chq.size();
        cycles(40);
        chk(chq.size(), n);
        chk(pwm, 0);
    endtask

    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        sc_startup();
        sc_order(1'b0, 4'h2);
        sc_order(1'b1, 4'h9);
        sc_pwm();
        sc_fault();
        sc_cv();
        conclude();
    end
endmodule
